// ---- rtl/asc_pkg.sv ----
// shared constants for the converter scan control and dma transfer-end block
package asc_pkg;
	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_UNITS  = 3;
	localparam int NUM_SCAN   = 4;
	localparam int CYC_W      = 10;
	localparam int CNT_W      = 16;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [29:0] IDX_ADC0_CSR  = 30'h0ffffa0;
	localparam logic [29:0] IDX_ADC0_CTL  = 30'h0ffffa1;
	localparam logic [29:0] IDX_ADC1_CSR  = 30'h0ffeaa0;
	localparam logic [29:0] IDX_ADC1_CTL  = 30'h0ffeaa1;
	localparam logic [29:0] IDX_ADC2_CSR  = 30'hffeeab0;
	localparam logic [29:0] IDX_ADC2_CTL  = 30'h0ffeab1;
	localparam logic [29:0] IDX_DMA0_MODE = 30'h0fffc14;
	localparam logic [29:0] IDX_DMA1_MODE = 30'h0fffc34;
	localparam logic [29:0] IDX_DMA2_MODE = 30'h0fffc54;
	localparam logic [29:0] IDX_DMA0_RSEL = 30'h0fffd20;
	localparam logic [29:0] IDX_DMA1_RSEL = 30'h0fffd21;
	localparam logic [29:0] IDX_DMA2_RSEL = 30'h0fffd22;
	localparam logic [29:0] IDX_DMA0_CNT  = 30'h0fffd30;
	localparam logic [29:0] IDX_DMA1_CNT  = 30'h0fffd31;
	localparam logic [29:0] IDX_DMA2_CNT  = 30'h0fffd32;
	localparam logic [29:0] IDX_IRQ_STAT  = 30'h0fffd40;
	localparam logic [29:0] IDX_IRQ_MASK  = 30'h0fffd41;

	// ----------------------------------------------------------------
	// control/status field positions
	// ----------------------------------------------------------------
	localparam int CSR_END_BIT   = 7;
	localparam int CSR_IE_BIT    = 6;
	localparam int CSR_START_BIT = 5;
	localparam int CSR_CKX_BIT   = 4;
	localparam int CSR_CH_LSB    = 0;
	localparam int CSR_CH_W      = 4;

	// control field positions
	localparam int CTL_TRG_LSB   = 6;
	localparam int CTL_SCAN_LSB  = 4;
	localparam int CTL_CKS_LSB   = 2;
	localparam int CTL_XTRG_BIT  = 0;
	localparam logic [1:0] SCAN_MODE_SCAN = 2'h2;

	// dma mode control fields
	localparam int DMA_EN_BIT    = 0;
	localparam int DMA_IE_BIT    = 8;
	localparam int DMA_FLAG_BIT  = 9;

	// request select codes naming each unit's conversion-end source
	localparam logic [7:0] RSEL_CODE [NUM_UNITS] = '{8'h56, 8'hed, 8'he8};

	// ----------------------------------------------------------------
	// conversion time per channel in peripheral clock cycles
	// ----------------------------------------------------------------
	localparam logic [CYC_W-1:0] CONV_CYC_CKS11   = 10'h044;
	localparam logic [CYC_W-1:0] CONV_CYC_EXT_BASE = 10'h028;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {ST_IDLE, ST_CONV} asc_unit_state_e;
endpackage

// ---- rtl/asc_top.sv ----
// converter scan control with dma transfer-end interrupt gating, axi4-lite slave
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module asc_top
	import asc_pkg::*;
(
	input  wire logic                      clk_i,
	input  wire logic                      resetn_i,
	input  wire logic [31:0]               s_axi_awaddr_i,
	input  wire logic                      s_axi_awvalid_i,
	output logic                           s_axi_awready_o,
	input  wire logic [31:0]               s_axi_wdata_i,
	input  wire logic [3:0]                s_axi_wstrb_i,
	input  wire logic                      s_axi_wvalid_i,
	output logic                           s_axi_wready_o,
	output logic [1:0]                     s_axi_bresp_o,
	output logic                           s_axi_bvalid_o,
	input  wire logic                      s_axi_bready_i,
	input  wire logic [31:0]               s_axi_araddr_i,
	input  wire logic                      s_axi_arvalid_i,
	output logic                           s_axi_arready_o,
	output logic [31:0]                    s_axi_rdata_o,
	output logic [1:0]                     s_axi_rresp_o,
	output logic                           s_axi_rvalid_o,
	input  wire logic                      s_axi_rready_i,
	input  wire logic [asc_pkg::NUM_UNITS-1:0] adc_trig_i,
	output logic [asc_pkg::NUM_UNITS-1:0]  conv_end_irq_o,
	output logic [asc_pkg::NUM_UNITS-1:0]  xfer_end_irq_o,
	output logic                           irq_o
);
	localparam int NU = NUM_UNITS;
	localparam int NI = 2 * NUM_UNITS;

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [31:0]      aw_addr_r;
	logic [31:0]      w_data_r;
	logic [3:0]       w_strb_r;
	logic             aw_full_r;
	logic             w_full_r;
	logic             wr_go;
	logic             wr_hit;
	logic             rd_hit;
	logic [31:0]      rd_data;
	logic [7:0]       csr_r    [NU];
	logic [7:0]       ctl_r    [NU];
	logic [31:0]      mode_r   [NU];
	logic [7:0]       rsel_r   [NU];
	logic [CNT_W-1:0] cnt_r    [NU];
	logic [NU-1:0]    trg_s1_r;
	logic [NU-1:0]    trg_s2_r;
	logic [NU-1:0]    trg_s3_r;
	logic [NU-1:0]    trg_lvl_r;
	logic [NU-1:0]    trg_rise;
	logic [NU-1:0]    done;
	logic [NU-1:0]    single_end;
	logic [NU-1:0]    cei_q_r;
	logic [NU-1:0]    xfer_req;
	logic [NU-1:0]    flag_set;
	logic [NI-1:0]    istat_r;
	logic [NI-1:0]    imask_r;

	// decode of a word address against a register index
	function automatic logic hit(input logic [31:0] a, input logic [29:0] idx);
		hit = (a == {idx, 2'b00});
	endfunction

	// ----------------------------------------------------------------
	// axi write channel capture
	// ----------------------------------------------------------------
	// address and data are taken in either order and held until the response
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			aw_full_r       <= 1'b0;
			w_full_r        <= 1'b0;
			aw_addr_r       <= '0;
			w_data_r        <= '0;
			w_strb_r        <= '0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o  <= 1'b0;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= RESP_OKAY;
		end
		else
		begin
			s_axi_awready_o <= !aw_full_r && !(s_axi_awvalid_i && s_axi_awready_o) && !s_axi_bvalid_o;
			s_axi_wready_o  <= !w_full_r && !(s_axi_wvalid_i && s_axi_wready_o) && !s_axi_bvalid_o;
			if (s_axi_awvalid_i && s_axi_awready_o)
			begin
				aw_full_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o)
			begin
				w_full_r <= 1'b1;
				w_data_r <= s_axi_wdata_i;
				w_strb_r <= s_axi_wstrb_i;
			end
			if (wr_go)
			begin
				aw_full_r      <= 1'b0;
				w_full_r       <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bvalid_o && s_axi_bready_i)
				s_axi_bvalid_o <= 1'b0;
		end
	end

	assign wr_go = aw_full_r && w_full_r && !s_axi_bvalid_o;

	// write address decode
	always_comb
	begin
		wr_hit = hit(aw_addr_r, IDX_IRQ_STAT) || hit(aw_addr_r, IDX_IRQ_MASK);
		for (int u = 0; u < NU; u++)
			wr_hit = wr_hit || hit(aw_addr_r, u == 0 ? IDX_ADC0_CSR : u == 1 ? IDX_ADC1_CSR : IDX_ADC2_CSR)
				|| hit(aw_addr_r, u == 0 ? IDX_ADC0_CTL : u == 1 ? IDX_ADC1_CTL : IDX_ADC2_CTL)
				|| hit(aw_addr_r, u == 0 ? IDX_DMA0_MODE : u == 1 ? IDX_DMA1_MODE : IDX_DMA2_MODE)
				|| hit(aw_addr_r, u == 0 ? IDX_DMA0_RSEL : u == 1 ? IDX_DMA1_RSEL : IDX_DMA2_RSEL)
				|| hit(aw_addr_r, u == 0 ? IDX_DMA0_CNT : u == 1 ? IDX_DMA1_CNT : IDX_DMA2_CNT);
	end

	// ----------------------------------------------------------------
	// axi read channel
	// ----------------------------------------------------------------
	// reads answer one cycle after the address is taken; no side effects
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= '0;
			s_axi_rresp_o   <= RESP_OKAY;
		end
		else
		begin
			s_axi_arready_o <= !s_axi_rvalid_o && !(s_axi_arvalid_i && s_axi_arready_o);
			if (s_axi_arvalid_i && s_axi_arready_o)
			begin
				s_axi_rvalid_o <= 1'b1;
				s_axi_rdata_o  <= rd_hit ? rd_data : '0;
				s_axi_rresp_o  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_rvalid_o && s_axi_rready_i)
				s_axi_rvalid_o <= 1'b0;
		end
	end

	// read mux; narrow registers sit in the low bits
	always_comb
	begin
		rd_hit  = 1'b1;
		rd_data = '0;
		if (hit(s_axi_araddr_i, IDX_IRQ_STAT))
			rd_data = 32'(istat_r);
		else if (hit(s_axi_araddr_i, IDX_IRQ_MASK))
			rd_data = 32'(imask_r);
		else
		begin
			rd_hit = 1'b0;
			for (int u = 0; u < NU; u++)
			begin
				if (hit(s_axi_araddr_i, u == 0 ? IDX_ADC0_CSR : u == 1 ? IDX_ADC1_CSR : IDX_ADC2_CSR))
				begin
					rd_hit  = 1'b1;
					rd_data = 32'(csr_r[u]);
				end
				if (hit(s_axi_araddr_i, u == 0 ? IDX_ADC0_CTL : u == 1 ? IDX_ADC1_CTL : IDX_ADC2_CTL))
				begin
					rd_hit  = 1'b1;
					rd_data = 32'(ctl_r[u]);
				end
				if (hit(s_axi_araddr_i, u == 0 ? IDX_DMA0_MODE : u == 1 ? IDX_DMA1_MODE : IDX_DMA2_MODE))
				begin
					rd_hit  = 1'b1;
					rd_data = mode_r[u];
				end
				if (hit(s_axi_araddr_i, u == 0 ? IDX_DMA0_RSEL : u == 1 ? IDX_DMA1_RSEL : IDX_DMA2_RSEL))
				begin
					rd_hit  = 1'b1;
					rd_data = 32'(rsel_r[u]);
				end
				if (hit(s_axi_araddr_i, u == 0 ? IDX_DMA0_CNT : u == 1 ? IDX_DMA1_CNT : IDX_DMA2_CNT))
				begin
					rd_hit  = 1'b1;
					rd_data = 32'(cnt_r[u]);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// external trigger pins
	// ----------------------------------------------------------------
	// three-stage sync; a level change counts once stages two and three agree
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			trg_s1_r  <= '0;
			trg_s2_r  <= '0;
			trg_s3_r  <= '0;
			trg_lvl_r <= '0;
		end
		else
		begin
			trg_s1_r <= adc_trig_i;
			trg_s2_r <= trg_s1_r;
			trg_s3_r <= trg_s2_r;
			for (int u = 0; u < NU; u++)
				if (trg_s2_r[u] == trg_s3_r[u])
					trg_lvl_r[u] <= trg_s3_r[u];
		end
	end

	assign trg_rise = trg_s2_r & trg_s3_r & ~trg_lvl_r;

	// ----------------------------------------------------------------
	// converter units
	// ----------------------------------------------------------------
	for (genvar g = 0; g < NU; g++)
	begin : g_unit
		asc_unit u_unit (
			.clk_i        (clk_i),
			.resetn_i     (resetn_i),
			.start_i      (csr_r[g][CSR_START_BIT]),
			.scan_i       (ctl_r[g][CTL_SCAN_LSB +: 2] == SCAN_MODE_SCAN),
			.cks_i        (ctl_r[g][CTL_CKS_LSB +: 2]),
			.ckx_i        (csr_r[g][CSR_CKX_BIT]),
			.done_o       (done[g]),
			.single_end_o (single_end[g])
		);
	end

	// ----------------------------------------------------------------
	// converter registers
	// ----------------------------------------------------------------
	// hardware set of the end flag wins over a software clear in the same cycle
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			for (int u = 0; u < NU; u++)
			begin
				csr_r[u] <= '0;
				ctl_r[u] <= '0;
			end
		end
		else
		begin
			for (int u = 0; u < NU; u++)
			begin
				if (wr_go && w_strb_r[0]
					&& hit(aw_addr_r, u == 0 ? IDX_ADC0_CSR : u == 1 ? IDX_ADC1_CSR : IDX_ADC2_CSR))
				begin
					csr_r[u][CSR_IE_BIT]               <= w_data_r[CSR_IE_BIT];
					csr_r[u][CSR_START_BIT]            <= w_data_r[CSR_START_BIT];
					csr_r[u][CSR_CKX_BIT]              <= w_data_r[CSR_CKX_BIT];
					csr_r[u][CSR_CH_LSB +: CSR_CH_W]   <= w_data_r[CSR_CH_LSB +: CSR_CH_W];
					if (!w_data_r[CSR_END_BIT])
						csr_r[u][CSR_END_BIT] <= 1'b0;
				end
				if (wr_go && w_strb_r[0]
					&& hit(aw_addr_r, u == 0 ? IDX_ADC0_CTL : u == 1 ? IDX_ADC1_CTL : IDX_ADC2_CTL))
					ctl_r[u] <= w_data_r[7:0];
				// external trigger starts only when a trigger source is selected
				if (trg_rise[u] && (ctl_r[u][CTL_TRG_LSB +: 2] != 2'h0 || ctl_r[u][CTL_XTRG_BIT]))
					csr_r[u][CSR_START_BIT] <= 1'b1;
				if (single_end[u])
					csr_r[u][CSR_START_BIT] <= 1'b0;
				if (done[u])
					csr_r[u][CSR_END_BIT] <= 1'b1;
			end
		end
	end

	// conversion-end interrupt straight from a flop of flag and enable
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			conv_end_irq_o <= '0;
			cei_q_r        <= '0;
		end
		else
		begin
			for (int u = 0; u < NU; u++)
				conv_end_irq_o[u] <= csr_r[u][CSR_END_BIT] && csr_r[u][CSR_IE_BIT];
			cei_q_r <= conv_end_irq_o;
		end
	end

	// ----------------------------------------------------------------
	// dma channels
	// ----------------------------------------------------------------
	// while enabled with a nonzero count, each rising conversion-end interrupt of the selected unit moves one item
	always_comb
	begin
		for (int c = 0; c < NU; c++)
		begin
			xfer_req[c] = 1'b0;
			for (int s = 0; s < NU; s++)
				if (rsel_r[c] == RSEL_CODE[s] && conv_end_irq_o[s] && !cei_q_r[s])
					xfer_req[c] = 1'b1;
			xfer_req[c] = xfer_req[c] && mode_r[c][DMA_EN_BIT] && cnt_r[c] != '0;
			flag_set[c] = xfer_req[c] && cnt_r[c] == CNT_W'(1);
		end
	end

	// mode, select and count registers; the flag is cleared by writing zero
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			for (int c = 0; c < NU; c++)
			begin
				mode_r[c] <= '0;
				rsel_r[c] <= '0;
				cnt_r[c]  <= '0;
			end
		end
		else
		begin
			for (int c = 0; c < NU; c++)
			begin
				if (wr_go && hit(aw_addr_r, c == 0 ? IDX_DMA0_MODE : c == 1 ? IDX_DMA1_MODE : IDX_DMA2_MODE))
				begin
					for (int b = 0; b < 4; b++)
						if (w_strb_r[b])
							mode_r[c][8*b +: 8] <= w_data_r[8*b +: 8];
					if (!w_strb_r[1] || w_data_r[DMA_FLAG_BIT])
						mode_r[c][DMA_FLAG_BIT] <= mode_r[c][DMA_FLAG_BIT];
				end
				if (wr_go && w_strb_r[0]
					&& hit(aw_addr_r, c == 0 ? IDX_DMA0_RSEL : c == 1 ? IDX_DMA1_RSEL : IDX_DMA2_RSEL))
					rsel_r[c] <= w_data_r[7:0];
				if (wr_go && hit(aw_addr_r, c == 0 ? IDX_DMA0_CNT : c == 1 ? IDX_DMA1_CNT : IDX_DMA2_CNT))
					cnt_r[c] <= w_data_r[CNT_W-1:0];
				else if (xfer_req[c])
					cnt_r[c] <= cnt_r[c] - CNT_W'(1);
				if (flag_set[c])
					mode_r[c][DMA_FLAG_BIT] <= 1'b1;
			end
		end
	end

	// transfer-end request follows enable and flag, dropping when either clears
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			xfer_end_irq_o <= '0;
		else
			for (int c = 0; c < NU; c++)
				xfer_end_irq_o[c] <= mode_r[c][DMA_IE_BIT] && mode_r[c][DMA_FLAG_BIT];
	end

	// ----------------------------------------------------------------
	// interrupt status and mask
	// ----------------------------------------------------------------
	// low bits: conversion done per unit; high bits: transfer end per channel
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			istat_r <= '0;
			imask_r <= '0;
			irq_o   <= 1'b0;
		end
		else
		begin
			if (wr_go && w_strb_r[0] && hit(aw_addr_r, IDX_IRQ_MASK))
				imask_r <= w_data_r[NI-1:0];
			// write-one-to-clear, with a new event in the same cycle winning
			istat_r <= (istat_r & ~((wr_go && w_strb_r[0] && hit(aw_addr_r, IDX_IRQ_STAT))
				? w_data_r[NI-1:0] : NI'(0))) | {flag_set, done};
			irq_o <= |(istat_r & imask_r);
		end
	end
endmodule
`default_nettype wire

// ---- rtl/asc_unit.sv ----
// one converter unit sequencer: channel timing and scan stepping
`timescale 1ns/10ps
`default_nettype none
module asc_unit
	import asc_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	input  wire logic       start_i,
	input  wire logic       scan_i,
	input  wire logic [1:0] cks_i,
	input  wire logic       ckx_i,
	output logic            done_o,
	output logic            single_end_o
);
	asc_unit_state_e          state_r;
	logic [CYC_W-1:0]         cnt_r;
	logic [1:0]               ch_r;
	logic [CYC_W-1:0]         lim;
	logic [CYC_W-1:0]         base;

	// ----------------------------------------------------------------
	// conversion time select
	// ----------------------------------------------------------------
	// slower settings double the cycle count per step
	always_comb
	begin
		base = ckx_i ? CONV_CYC_EXT_BASE : CONV_CYC_CKS11;
		case (cks_i)
			2'h3:    lim = base;
			2'h2:    lim = CYC_W'({base, 1'b0});
			2'h1:    lim = CYC_W'({base, 2'b00});
			default: lim = CYC_W'({base, 3'b000});
		endcase
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	// clearing start aborts mid-channel; no partial result is flagged
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			state_r      <= ST_IDLE;
			cnt_r        <= '0;
			ch_r         <= '0;
			done_o       <= 1'b0;
			single_end_o <= 1'b0;
		end
		else
		begin
			done_o       <= 1'b0;
			single_end_o <= 1'b0;
			case (state_r)
				ST_IDLE:
				begin
					cnt_r <= '0;
					ch_r  <= '0;
					if (start_i)
						state_r <= ST_CONV;
				end
				ST_CONV:
				begin
					if (!start_i)
						state_r <= ST_IDLE;
					else if (cnt_r == lim - CYC_W'(1))
					begin
						cnt_r <= '0;
						if (!scan_i)
						begin
							done_o       <= 1'b1;
							single_end_o <= 1'b1;
							state_r      <= ST_IDLE;
						end
						else if (ch_r == 2'(NUM_SCAN - 1))
						begin
							done_o <= 1'b1;
							ch_r   <= '0;
						end
						else
							ch_r <= ch_r + 2'h1;
					end
					else
						cnt_r <= cnt_r + CYC_W'(1);
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- sim/asc_chk_assertions.sv ----
// checker of bus handshakes and interrupt outputs of the scan control block
`timescale 1ns/10ps
`default_nettype none
module asc_chk
	import asc_pkg::*;
(
	input wire logic                          clk_i,
	input wire logic                          resetn_i,
	input wire logic                          s_axi_awready_o,
	input wire logic                          s_axi_wready_o,
	input wire logic [1:0]                    s_axi_bresp_o,
	input wire logic                          s_axi_bvalid_o,
	input wire logic                          s_axi_bready_i,
	input wire logic [31:0]                   s_axi_araddr_i,
	input wire logic                          s_axi_arvalid_i,
	input wire logic                          s_axi_arready_o,
	input wire logic [31:0]                   s_axi_rdata_o,
	input wire logic [1:0]                    s_axi_rresp_o,
	input wire logic                          s_axi_rvalid_o,
	input wire logic                          s_axi_rready_i,
	input wire logic [asc_pkg::NUM_UNITS-1:0] conv_end_irq_o,
	input wire logic [asc_pkg::NUM_UNITS-1:0] xfer_end_irq_o,
	input wire logic                          irq_o
);
	// ----------------------------------------------------------------
	// helper: cycles since a conversion-end level or a write answer
	// ----------------------------------------------------------------
	logic [3:0] quiet_r;
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			quiet_r <= 4'h0;
		else if (|conv_end_irq_o || s_axi_bvalid_o)
			quiet_r <= 4'h0;
		else if (quiet_r != 4'hf)
			quiet_r <= quiet_r + 4'h1; // saturates, never wraps
	end
	default clocking dcb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read answer late");
	a_rd_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read answer not held");
	a_b_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write answer not held");
	a_rd_single: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
		else $error("second read taken");
	a_wr_single: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("second write taken");
	a_rd_unmapped: assert property (s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == 32'h0
		|=> s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h0) else $error("unmapped read answered");
	// interrupts are withdrawn only by software writes
	a_xirq_drop: assert property (|($past(xfer_end_irq_o) & ~xfer_end_irq_o) |-> $past(s_axi_bvalid_o))
		else $error("xirq drop");
	a_cirq_drop: assert property (|($past(conv_end_irq_o) & ~conv_end_irq_o) |-> $past(s_axi_bvalid_o))
		else $error("cirq drop");
	a_xirq_cause: assert property (|(xfer_end_irq_o & ~$past(xfer_end_irq_o)) |-> quiet_r < 4'h8)
		else $error("xirq cause");
	a_irq_drop: assert property ($past(irq_o) && !irq_o |-> $past(s_axi_bvalid_o))
		else $error("irq drop");
	c_conv_end: cover property (|conv_end_irq_o);
	c_xfer_end: cover property (|xfer_end_irq_o);
	c_irq: cover property ($rose(irq_o));
endmodule
bind asc_top asc_chk asc_chk_i (.*);
`default_nettype wire

// ---- sim/asc_cpu.sv ----
// bus master model standing in for the cpu on the register side
`timescale 1ns/10ps
`default_nettype none
module asc_cpu
(
	input  wire logic        clk_i,
	output logic [31:0]      awaddr_o,
	output logic             awvalid_o,
	input  wire logic        awready_i,
	output logic [31:0]      wdata_o,
	output logic [3:0]       wstrb_o,
	output logic             wvalid_o,
	input  wire logic        wready_i,
	input  wire logic [1:0]  bresp_i,
	input  wire logic        bvalid_i,
	output logic             bready_o,
	output logic [31:0]      araddr_o,
	output logic             arvalid_o,
	input  wire logic        arready_i,
	input  wire logic [31:0] rdata_i,
	input  wire logic [1:0]  rresp_i,
	input  wire logic        rvalid_i,
	output logic             rready_o
);
	// idle bus at time zero
	initial
	begin
		{awaddr_o, wdata_o, araddr_o, wstrb_o, awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = '0;
	end
	// write one word; a channel lets go at the edge that takes it
	task automatic wr(input logic [29:0] idx, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk_i);
		{awaddr_o, wdata_o, wstrb_o} <= {idx, 2'h0, d, 4'hf};
		{awvalid_o, wvalid_o, bready_o} <= 3'h7;
		do
		begin
			@(posedge clk_i);
			if (awvalid_o && awready_i) {awvalid_o, awaddr_o} <= {1'h0, ~awaddr_o}; // released lines do not keep the value
			if (wvalid_o && wready_i) {wvalid_o, wdata_o} <= {1'h0, ~wdata_o};
		end
		while (!bvalid_i);
		r = bresp_i;
		bready_o <= 1'h0;
	endtask
	// read one word
	task automatic rd(input logic [29:0] idx, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_i);
		{araddr_o, arvalid_o, rready_o} <= {idx, 2'h0, 2'h3};
		do
		begin
			@(posedge clk_i);
			if (arvalid_o && arready_i) {arvalid_o, araddr_o} <= {1'h0, ~araddr_o};
		end
		while (!rvalid_i);
		{d, r} = {rdata_i, rresp_i};
		rready_o <= 1'h0;
	endtask
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench: register rows, scan timing, triggers, dma end interrupts
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import asc_pkg::*;
	typedef struct {logic [29:0] a; logic [31:0] w, r; logic [1:0] e;} asc_row_s;
	logic        clk_i, resetn_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
	logic        s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i, irq_o;
	logic [31:0] s_axi_awaddr_i, s_axi_wdata_i, s_axi_araddr_i, s_axi_rdata_o, rv;
	logic [3:0]  s_axi_wstrb_i;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rs;
	logic [NUM_UNITS-1:0] adc_trig_i, conv_end_irq_o, xfer_end_irq_o;
	int          err_total, comparisons, n;
	asc_row_s    rows [7];
	asc_top asc_top_i (.*);
	asc_cpu asc_cpu_i (.clk_i(clk_i), .awaddr_o(s_axi_awaddr_i), .awvalid_o(s_axi_awvalid_i),
		.awready_i(s_axi_awready_o), .wdata_o(s_axi_wdata_i), .wstrb_o(s_axi_wstrb_i), .wvalid_o(s_axi_wvalid_i),
		.wready_i(s_axi_wready_o), .bresp_i(s_axi_bresp_o), .bvalid_i(s_axi_bvalid_o), .bready_o(s_axi_bready_i),
		.araddr_o(s_axi_araddr_i), .arvalid_o(s_axi_arvalid_i), .arready_i(s_axi_arready_o), .rdata_i(s_axi_rdata_o),
		.rresp_i(s_axi_rresp_o), .rvalid_i(s_axi_rvalid_o), .rready_o(s_axi_rready_i));
	// 40 ns clock; watchdog well past the run
	initial
	begin
		clk_i = 1'h0;
		forever #20 clk_i = ~clk_i;
	end
	initial
	begin
		#(40 * 20000);
		err_total++;
		results();
	end
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
	endtask
	task automatic wq(input logic [29:0] a, input logic [31:0] d);
		asc_cpu_i.wr(a, d, rs);
		cmp("bresp", RESP_OKAY, rs);
	endtask
	task automatic rc(input string nm, input logic [29:0] a, input logic [31:0] e);
		asc_cpu_i.rd(a, rv, rs);
		cmp(nm, e, rv);
	endtask
	// bounded wait, counted in cycles, for a unit's conversion-end request
	task automatic wait_ce(input int u);
		n = 0;
		while (conv_end_irq_o[u] !== 1'h1 && n < 1000)
		begin
			@(negedge clk_i);
			n++;
		end
	endtask
	task automatic trig(input int u);
		adc_trig_i[u] <= 1'h1;
		tick(4);
		adc_trig_i[u] <= 1'h0;
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		{resetn_i, adc_trig_i, err_total, comparisons, n} = '0;
		rows = '{'{IDX_ADC0_CTL, 32'h1cd, 32'hcd, RESP_OKAY},
			'{IDX_ADC1_CSR, 32'h90, 32'h10, RESP_OKAY},
			'{IDX_DMA0_RSEL, 32'h56, 32'h56, RESP_OKAY},
			'{IDX_DMA1_CNT, 32'h12345, 32'h2345, RESP_OKAY},
			'{IDX_DMA2_MODE, 32'h301, 32'h101, RESP_OKAY},
			'{IDX_IRQ_MASK, 32'h3f, 32'h3f, RESP_OKAY},
			'{30'h0, 32'h1, 32'h0, RESP_SLVERR}};
		tick(10);
		resetn_i <= 1'h1;
		tick(3);
		// reset value, write, read back; end flag and dma flag ignore written ones
		foreach (rows[i])
		begin
			rc("reset value", rows[i].a, 32'h0);
			asc_cpu_i.wr(rows[i].a, rows[i].w, rs);
			cmp("wresp", rows[i].e, rs);
			asc_cpu_i.rd(rows[i].a, rv, rs);
			cmp("rresp", rows[i].e, rs);
			cmp("rdata", rows[i].r, rv);
		end
		$display("test reset and rows done");
		// unit 0: four channels of 68 cycles, then enable off and stop
		wq(IDX_ADC0_CTL, 32'h2c);
		wq(IDX_ADC0_CSR, 32'h60);
		wait_ce(0);
		cmp("scan time", 32'h1, 32'(n > 240 && n <= 278));
		tick(2);
		cmp("irq", 32'h1, irq_o);
		rc("csr0 done", IDX_ADC0_CSR, 32'he0);
		wq(IDX_ADC0_CSR, 32'ha0);
		tick(2);
		cmp("ce0 blocked", 32'h0, conv_end_irq_o[0]);
		wq(IDX_ADC0_CSR, 32'h0);
		tick(300);
		rc("csr0 stopped", IDX_ADC0_CSR, 32'h0);
		$display("test scan done");
		// unit 1, slower clock with extension bit: triggers ignored until a source is selected
		wq(IDX_ADC1_CTL, 32'h08);
		wq(IDX_ADC1_CSR, 32'h10);
		trig(1);
		tick(200);
		rc("no trigger", IDX_ADC1_CSR, 32'h10);
		wq(IDX_ADC1_CTL, 32'h09);
		trig(1);
		tick(200);
		rc("trigger", IDX_ADC1_CSR, 32'h90);
		cmp("ce1 off", 32'h0, conv_end_irq_o[1]);
		$display("test trigger done");
		// unit 2 feeds dma 2 twice; dma 1 selects no source
		wq(IDX_IRQ_MASK, 32'h0);
		wq(IDX_IRQ_STAT, 32'h3f);
		wq(IDX_DMA2_RSEL, 32'he8);
		wq(IDX_DMA2_CNT, 32'h2);
		wq(IDX_DMA2_MODE, 32'h101);
		wq(IDX_DMA1_RSEL, 32'h0);
		wq(IDX_DMA1_CNT, 32'h1);
		wq(IDX_DMA1_MODE, 32'h101);
		wq(IDX_ADC2_CTL, 32'h2c);
		wq(IDX_ADC2_CSR, 32'h60);
		repeat (2)
		begin
			wait_ce(2);
			wq(IDX_ADC2_CSR, 32'h60);
			tick(1);
		end
		tick(4);
		cmp("xfer2", 32'h1, xfer_end_irq_o[2]);
		cmp("xfer1", 32'h0, xfer_end_irq_o[1]);
		cmp("masked", 32'h0, irq_o);
		wq(IDX_IRQ_MASK, 32'h20);
		tick(2);
		cmp("unmasked", 32'h1, irq_o);
		// handler: enable off keeps the flag, flag clear, unit stop
		wq(IDX_DMA2_MODE, 32'h201);
		tick(2);
		cmp("xfer2 ie0", 32'h0, xfer_end_irq_o[2]);
		rc("mode2", IDX_DMA2_MODE, 32'h201);
		wq(IDX_DMA2_MODE, 32'h301);
		tick(2);
		cmp("xfer2 ie1", 32'h1, xfer_end_irq_o[2]);
		wq(IDX_DMA2_MODE, 32'h101);
		tick(2);
		cmp("xfer2 clr", 32'h0, xfer_end_irq_o[2]);
		wq(IDX_ADC2_CSR, 32'h0);
		wq(IDX_IRQ_STAT, 32'h3f);
		tick(2);
		cmp("irq clr", 32'h0, irq_o);
		$display("test dma done");
		// second reset in mid-run
		resetn_i <= 1'h0;
		tick(2);
		resetn_i <= 1'h1;
		tick(3);
		rc("reset again", IDX_IRQ_MASK, 32'h0);
		$display("test reset again done");
		results();
	end
endmodule
`default_nettype wire
